// ===== cpp_device.sv
`timescale 1ns/100ps
`include "cpp_defines.svh"
module cpp_device #(
    parameter logic [31:0] DEVICE_ID = 32'h0A5C_0001, // Arbitrary identifier value
    parameter int FRAMES = 2
) (
    input wire logic sys_clk_in, // Clock, 100 MHz
    input wire logic rst_b_in, // Async reset, active low
    cpp_link_if.device link, // Word stream from host
    output logic serial_chain_out, // Serial daisy-chain data
    output logic chain_select_b_out, // Parallel chain select, active low
    output logic [31:0] user_access_word_out, // User-visible word
    output logic [31:0] control_word_0_out, // Control word 0
    output logic [31:0] control_word_1_out, // Control word 1
    output logic cmd_strobe_out, // Command execute pulse
    output logic [4:0] cmd_code_out, // Command code executed
    output logic start_ok_out, // Startup permitted
    output logic [31:0] cipher_init_vector_out, // Decryption init vector
    output logic [31:0] multi_frame_write_out // Multi-frame write word
);
    localparam int FW = $clog2(FRAMES);
    // ------------------------------------------------------------------
    // Parser state
    // ------------------------------------------------------------------
    cpp_pkg::cpp_parse_e st_q;
    cpp_pkg::cpp_addr_t addr_q;
    logic have_addr_q;
    logic [26:0] cnt_q;
    logic [31:0] w;
    logic take;
    logic wr_word;
    assign w = link.wr_data;
    assign take = link.wr_valid && link.wr_ready;
    assign wr_word = take && (st_q == cpp_pkg::CPP_PS_WR);
    // Data registers
    logic [31:0] crc_q, fadr_q, cmd_q, mask_q, copt0_q, copt1_q, user_q;
    logic [31:0] wboot_q, wdog_q, boot_q, ivec_q, mfw_q, ctrl0_q, ctrl1_q;
    logic crc_err_q, id_ok_q, id_err_q, start_ok_q;
    logic [5:0] fword_q;
    logic [FW-1:0] fidx_q;
    logic [31:0] fmem_rd;
    logic [31:0] sh_q;
    logic [5:0] sh_cnt_q;

    function automatic logic hit(input cpp_pkg::cpp_addr_t a, input cpp_pkg::cpp_addr_t r);
        hit = (a == r);
    endfunction

    // ------------------------------------------------------------------
    // Packet parser
    // ------------------------------------------------------------------
    // Reads stall until the host accepts the answer word
    assign link.wr_ready = (st_q != cpp_pkg::CPP_PS_RD) && (sh_cnt_q == 6'h00);
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= cpp_pkg::CPP_PS_HDR;
            addr_q <= 5'h00;
            have_addr_q <= 1'b0;
            cnt_q <= 27'h0;
        end
        else if (st_q == cpp_pkg::CPP_PS_RD)
        begin
            if (link.rd_ready)
            begin
                cnt_q <= cnt_q - 27'h1;
                if (cnt_q == 27'h1) st_q <= cpp_pkg::CPP_PS_HDR;
            end
        end
        else if (take)
        begin
            case (st_q)
                cpp_pkg::CPP_PS_HDR:
                begin
                    if (w[`CPP_HDR_TYPE_MSB:`CPP_HDR_TYPE_LSB] == `CPP_HDR_TYPE1)
                    begin
                        addr_q <= w[`CPP_HDR_ADDR_MSB:`CPP_HDR_ADDR_LSB];
                        have_addr_q <= 1'b1;
                        cnt_q <= {16'h0, w[`CPP_HDR_WC1_MSB:0]};
                        if (w[`CPP_HDR_WC1_MSB:0] != 11'h0)
                        begin
                            case (w[`CPP_HDR_OP_MSB:`CPP_HDR_OP_LSB])
                                2'b10: st_q <= cpp_pkg::CPP_PS_WR;
                                2'b01: st_q <= cpp_pkg::CPP_PS_RD;
                                default: st_q <= cpp_pkg::CPP_PS_SKIP;
                            endcase
                        end
                    end
                    else if (w[`CPP_HDR_TYPE_MSB:`CPP_HDR_TYPE_LSB] == `CPP_HDR_TYPE2)
                    begin
                        cnt_q <= w[`CPP_HDR_WC2_MSB:0];
                        if (w[`CPP_HDR_WC2_MSB:0] != 27'h0)
                            // Reuse last address, drop if none yet
                            st_q <= have_addr_q ? cpp_pkg::CPP_PS_WR
                                                : cpp_pkg::CPP_PS_SKIP;
                    end
                end
                cpp_pkg::CPP_PS_WR, cpp_pkg::CPP_PS_SKIP:
                begin
                    cnt_q <= cnt_q - 27'h1;
                    if (cnt_q == 27'h1) st_q <= cpp_pkg::CPP_PS_HDR;
                end
                default: st_q <= cpp_pkg::CPP_PS_HDR;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Plain register writes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            crc_q <= `CPP_RST_WORD;
            fadr_q <= `CPP_RST_WORD;
            cmd_q <= `CPP_RST_WORD;
            mask_q <= `CPP_RST_MASK;
            copt0_q <= `CPP_RST_WORD;
            copt1_q <= `CPP_RST_WORD;
            user_q <= `CPP_RST_WORD;
            wboot_q <= `CPP_RST_WORD;
            wdog_q <= `CPP_RST_WORD;
            ivec_q <= `CPP_RST_WORD;
            mfw_q <= `CPP_RST_WORD;
        end
        else if (wr_word)
        begin
            case (addr_q)
                `CPP_A_CRC: crc_q <= w;
                `CPP_A_FADR: fadr_q <= w;
                `CPP_A_CMD: cmd_q <= {27'h0, w[4:0]};
                `CPP_A_MASK: mask_q <= w;
                `CPP_A_COPT0: copt0_q <= w;
                `CPP_A_COPT1: copt1_q <= w;
                `CPP_A_USER: user_q <= w;
                `CPP_A_WBOOT: wboot_q <= w;
                `CPP_A_WDOG: wdog_q <= w;
                `CPP_A_IVEC: ivec_q <= w;
                `CPP_A_MFW: mfw_q <= w;
                default: ;
            endcase
        end
    end

    // Masked control words
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ctrl0_q <= `CPP_RST_WORD;
            ctrl1_q <= `CPP_RST_WORD;
        end
        else if (wr_word)
        begin
            if (hit(addr_q, `CPP_A_CTRL0)) ctrl0_q <= (ctrl0_q & ~mask_q) | (w & mask_q);
            if (hit(addr_q, `CPP_A_CTRL1)) ctrl1_q <= (ctrl1_q & ~mask_q) | (w & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Check word, identifier gate, boot history
    // ------------------------------------------------------------------
    // Running check value is a simple additive sum of written words; a
    // full polynomial is not modelled
    logic [31:0] calc_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            calc_q <= `CPP_RST_WORD;
            crc_err_q <= 1'b1;
            start_ok_q <= 1'b0;
            id_ok_q <= 1'b0;
            id_err_q <= 1'b0;
            boot_q <= `CPP_RST_WORD;
        end
        else if (wr_word)
        begin
            if (hit(addr_q, `CPP_A_CRC))
            begin
                if (w == calc_q)
                begin
                    crc_err_q <= 1'b0;
                    start_ok_q <= 1'b1;
                end
                else crc_err_q <= 1'b1;
            end
            else calc_q <= calc_q + w;
            if (hit(addr_q, `CPP_A_DEVID))
            begin
                id_ok_q <= (w == DEVICE_ID);
                id_err_q <= (w != DEVICE_ID);
                boot_q <= {31'h0, w != DEVICE_ID};
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame data in/out and command execution
    // ------------------------------------------------------------------
    logic fmem_we;
    logic rd_fout;
    assign rd_fout = (st_q == cpp_pkg::CPP_PS_RD) && hit(addr_q, `CPP_A_FOUT) && link.rd_ready;
    // Frame input gated on a matching identifier
    assign fmem_we = wr_word && hit(addr_q, `CPP_A_FIN) && id_ok_q;
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            fword_q <= 6'h00;
            fidx_q <= '0;
        end
        else if (wr_word && hit(addr_q, `CPP_A_FADR))
        begin
            fword_q <= 6'h00;
            fidx_q <= FW'(w);
        end
        else if (fmem_we || rd_fout)
        begin
            if (fword_q == 6'(`CPP_FRAME_WORDS - 1))
            begin
                fword_q <= 6'h00;
                fidx_q <= FW'(fidx_q + 1'b1);
            end
            else fword_q <= fword_q + 6'h01;
        end
    end
    cpp_frame_mem #(.FRAMES(FRAMES)) u_mem (
        .sys_clk_in(sys_clk_in),
        .frame_in(fidx_q),
        .word_in(fword_q),
        .wr_en_in(fmem_we),
        .wr_data_in(w),
        .rd_data_out(fmem_rd)
    );
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cmd_strobe_out <= 1'b0;
            cmd_code_out <= 5'h00;
        end
        else
        begin
            cmd_strobe_out <= wr_word && (hit(addr_q, `CPP_A_CMD) || hit(addr_q, `CPP_A_FADR));
            cmd_code_out <= hit(addr_q, `CPP_A_CMD) ? w[4:0] : cmd_q[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Read answer mux and daisy-chain outputs
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        case (addr_q)
            `CPP_A_CRC: rd_mux = crc_q;
            `CPP_A_FADR: rd_mux = fadr_q;
            `CPP_A_FOUT: rd_mux = fmem_rd;
            `CPP_A_CMD: rd_mux = cmd_q;
            `CPP_A_CTRL0: rd_mux = ctrl0_q;
            `CPP_A_MASK: rd_mux = mask_q;
            `CPP_A_STAT: rd_mux = {27'h0, id_err_q, have_addr_q, start_ok_q, id_ok_q, crc_err_q};
            `CPP_A_COPT0: rd_mux = copt0_q;
            `CPP_A_DEVID: rd_mux = DEVICE_ID;
            `CPP_A_USER: rd_mux = user_q;
            `CPP_A_COPT1: rd_mux = copt1_q;
            `CPP_A_WBOOT: rd_mux = wboot_q;
            `CPP_A_WDOG: rd_mux = wdog_q;
            `CPP_A_BOOT: rd_mux = boot_q;
            `CPP_A_CTRL1: rd_mux = ctrl1_q;
            default: rd_mux = `CPP_RST_WORD;
        endcase
    end
    assign link.rd_data = rd_mux;
    assign link.rd_valid = (st_q == cpp_pkg::CPP_PS_RD);
    // Serial chain: word shifted out MSB first, 32 clocks, stalls parser
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sh_q <= `CPP_RST_WORD;
            sh_cnt_q <= 6'h00;
            serial_chain_out <= 1'b0;
            chain_select_b_out <= 1'b1;
        end
        else
        begin
            if (wr_word && hit(addr_q, `CPP_A_SOUT))
            begin
                sh_q <= w;
                sh_cnt_q <= 6'd32;
            end
            else if (sh_cnt_q != 6'h00)
            begin
                serial_chain_out <= sh_q[31];
                sh_q <= {sh_q[30:0], 1'b0};
                sh_cnt_q <= sh_cnt_q - 6'h01;
            end
            if (wr_word && hit(addr_q, `CPP_A_PSEL)) chain_select_b_out <= w[0];
        end
    end
    assign user_access_word_out = user_q;
    assign control_word_0_out = ctrl0_q;
    assign control_word_1_out = ctrl1_q;
    assign start_ok_out = start_ok_q;
    assign cipher_init_vector_out = ivec_q;
    assign multi_frame_write_out = mfw_q;
endmodule // cpp_device

// ===== cpp_defines.svh
`ifndef CPP_DEFINES_SVH
`define CPP_DEFINES_SVH
// ----------------------------------------------------------------------
// Header word fields
// ----------------------------------------------------------------------
`define CPP_HDR_TYPE_MSB 31
`define CPP_HDR_TYPE_LSB 29
`define CPP_HDR_OP_MSB 28
`define CPP_HDR_OP_LSB 27
`define CPP_HDR_ADDR_MSB 17
`define CPP_HDR_ADDR_LSB 13
`define CPP_HDR_ADDR_FULL_LSB 13
`define CPP_HDR_ADDR_FULL_MSB 26
`define CPP_HDR_WC1_MSB 10
`define CPP_HDR_WC2_MSB 26
`define CPP_HDR_TYPE1 3'h1
`define CPP_HDR_TYPE2 3'h2
// ----------------------------------------------------------------------
// Register addresses (five-bit)
// ----------------------------------------------------------------------
`define CPP_A_CRC 5'h00
`define CPP_A_FADR 5'h01
`define CPP_A_FIN 5'h02
`define CPP_A_FOUT 5'h03
`define CPP_A_CMD 5'h04
`define CPP_A_CTRL0 5'h05
`define CPP_A_MASK 5'h06
`define CPP_A_STAT 5'h07
`define CPP_A_SOUT 5'h08
`define CPP_A_COPT0 5'h09
`define CPP_A_MFW 5'h0A
`define CPP_A_IVEC 5'h0B
`define CPP_A_DEVID 5'h0C
`define CPP_A_USER 5'h0D
`define CPP_A_COPT1 5'h0E
`define CPP_A_PSEL 5'h0F
`define CPP_A_WBOOT 5'h10
`define CPP_A_WDOG 5'h11
`define CPP_A_BOOT 5'h16
`define CPP_A_CTRL1 5'h18
// ----------------------------------------------------------------------
// Frame and status layout, reset values
// ----------------------------------------------------------------------
`define CPP_FRAME_WORDS 41
`define CPP_CMD_CODE_W 5
`define CPP_ST_CRC_ERR 0
`define CPP_ST_ID_OK 1
`define CPP_ST_START_OK 2
`define CPP_ST_HAVE_ADDR 3
`define CPP_ST_ID_ERR 4
`define CPP_RST_WORD 32'h0000_0000
`define CPP_RST_MASK 32'hFFFF_FFFF
// ----------------------------------------------------------------------
// Host APB register offsets (byte)
// ----------------------------------------------------------------------
`define CPP_H_DATA 12'h000
`define CPP_H_STATUS 12'h004
`define CPP_H_RDATA 12'h008
`define CPP_H_COUNT 12'h00C
`define CPP_H_ST_BUSY 0
`define CPP_H_ST_RVALID 1
`endif

// ===== cpp_pkg.sv
package cpp_pkg;
    typedef enum logic [3:0] {
        CPP_PS_HDR = 4'b0001,
        CPP_PS_WR = 4'b0010,
        CPP_PS_RD = 4'b0100,
        CPP_PS_SKIP = 4'b1000
    } cpp_parse_e;
    typedef logic [4:0] cpp_addr_t;
endpackage

// ===== cpp_link_if.sv
`timescale 1ns/100ps
// Word stream between configuration host and device
interface cpp_link_if;
    logic [31:0] wr_data;
    logic wr_valid;
    logic wr_ready;
    logic [31:0] rd_data;
    logic rd_valid;
    logic rd_ready;
    modport host (output wr_data, output wr_valid, input wr_ready,
                  input rd_data, input rd_valid, output rd_ready);
    modport device (input wr_data, input wr_valid, output wr_ready,
                    output rd_data, output rd_valid, input rd_ready);
endinterface

// ===== cpp_frame_mem.sv
`timescale 1ns/100ps
`include "cpp_defines.svh"
// Frame storage: FRAMES frames of 41 words, flip-flops addressed by index
module cpp_frame_mem #(
    parameter int FRAMES = 2
) (
    input wire logic sys_clk_in, // Clock
    input wire logic [$clog2(FRAMES)-1:0] frame_in, // Frame index
    input wire logic [5:0] word_in, // Word within frame
    input wire logic wr_en_in, // Write strobe
    input wire logic [31:0] wr_data_in, // Write word
    output logic [31:0] rd_data_out // Read word, combinational
);
    initial
    begin
        if (FRAMES < 2) $error("FRAMES must be at least 2");
    end
    logic [31:0] mem_q [FRAMES*`CPP_FRAME_WORDS];
    logic [$clog2(FRAMES*`CPP_FRAME_WORDS)-1:0] idx;
    // Flat index; no reset, contents are configuration data
    assign idx = ($clog2(FRAMES*`CPP_FRAME_WORDS))'(frame_in * `CPP_FRAME_WORDS + word_in);
    always_ff @(posedge sys_clk_in)
    begin
        if (wr_en_in) mem_q[idx] <= wr_data_in;
    end
    assign rd_data_out = mem_q[idx];
endmodule // cpp_frame_mem

// ===== cpp_host.sv
`timescale 1ns/100ps
`include "cpp_defines.svh"
// Host end: APB slave taking words from software and feeding the stream
module cpp_host (
    input wire logic sys_clk_in, // Clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    cpp_link_if.host link // Word stream to device
);
    // ------------------------------------------------------------------
    // Stream side: one outstanding word; host keeps header order itself
    // ------------------------------------------------------------------
    logic [31:0] wd_q, rd_q, cnt_q;
    logic wv_q, rv_q;
    logic acc;
    assign acc = psel && penable;
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wd_q <= 32'h0000_0000;
            wv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rv_q <= 1'b0;
            cnt_q <= 32'h0000_0000;
        end
        else
        begin
            // Data write only accepted while idle: pready held low otherwise
            if (acc && pwrite && paddr == `CPP_H_DATA && !wv_q)
            begin
                wd_q <= pwdata;
                wv_q <= 1'b1;
            end
            else if (wv_q && link.wr_ready)
            begin
                wv_q <= 1'b0;
                cnt_q <= cnt_q + 32'h1;
            end
            if (link.rd_valid && !rv_q)
            begin
                rd_q <= link.rd_data;
                rv_q <= 1'b1;
            end
            else if (acc && !pwrite && paddr == `CPP_H_RDATA) rv_q <= 1'b0;
        end
    end
    assign link.wr_data = wd_q;
    assign link.wr_valid = wv_q;
    assign link.rd_ready = link.rd_valid && !rv_q;
    // APB answer, combinational ready, zero for unmapped addresses
    always_comb
    begin
        pready = !(pwrite && paddr == `CPP_H_DATA && wv_q);
        pslverr = 1'b0;
        case (paddr)
            `CPP_H_STATUS: prdata = {30'h0, rv_q, wv_q};
            `CPP_H_RDATA: prdata = rd_q;
            `CPP_H_COUNT: prdata = cnt_q;
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule // cpp_host

// ===== cpp_link_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Word stream checks between host and device
// ----------------------------------------------------------------------
module cpp_link_props (
    input wire logic sys_clk_in, // Clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic [31:0] wr_data, // Host to device word
    input wire logic wr_valid, // Host word valid
    input wire logic wr_ready, // Device takes word
    input wire logic [31:0] rd_data, // Device to host word
    input wire logic rd_valid, // Device word valid
    input wire logic rd_ready // Host takes word
);
    logic hdr_q;
    logic [26:0] wcnt_q;
    logic [10:0] rcnt_q;
    wire take = wr_valid & wr_ready;
    wire rtake = rd_valid & rd_ready;
    wire [2:0] typ = wr_data[31:29];
    wire [1:0] op = wr_data[28:27];
    wire rd_hdr = take && hdr_q && typ == 3'h1 && op == 2'h1 && wr_data[10:0] != 11'h000;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Mirror of packet framing, so data words are never mistaken for headers
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            hdr_q <= 1'b1;
            wcnt_q <= 27'h0;
        end
        else if (take && !hdr_q)
        begin
            wcnt_q <= wcnt_q - 27'h1;
            hdr_q <= (wcnt_q == 27'h1);
        end
        // Writes, no-operation and reserved packets all carry their counted words
        else if (take && typ == 3'h1 && op != 2'h1 && wr_data[10:0] != 11'h000)
        begin
            wcnt_q <= {16'h0, wr_data[10:0]};
            hdr_q <= 1'b0;
        end
        else if (take && typ == 3'h2 && wr_data[26:0] != 27'h0)
        begin
            wcnt_q <= wr_data[26:0];
            hdr_q <= 1'b0;
        end
    end
    // Words still owed to the host by the current read packet
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rcnt_q <= 11'h0;
        else if (rd_hdr)
            rcnt_q <= wr_data[10:0];
        else if (rtake)
            rcnt_q <= rcnt_q - 11'h1;
    end
    a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("host word changed before it was taken");
    a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("device word changed before it was taken");
    a_rd_only: assert property (rd_valid |-> rcnt_q != 11'h0)
        else $error("read word offered outside a read packet");
    a_rd_answer: assert property (rd_hdr |-> ##[1:100] rd_valid)
        else $error("read packet gave no word");
    a_rd_count: assert property (rtake && rcnt_q == 11'h1 |=> !rd_valid)
        else $error("read packet gave too many words");
    a_rd_blocks: assert property (rd_valid |-> !wr_ready)
        else $error("stream taken during read packet");
    a_rd_starts: assert property (rd_hdr |=> !wr_ready)
        else $error("stream not paused after read header");
    a_ready_back: assert property (!wr_ready && rcnt_q == 11'h0 |-> ##[0:64] wr_ready)
        else $error("stream stalled too long");
endmodule // cpp_link_props

// ===== cpp_tb.sv
`timescale 1ns/100ps
module testbench;
    localparam logic [31:0] OWN_ID = 32'h1357_2468; // Arbitrary identifier value
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q, d;
    logic pready, pslverr, ser, csel_b, strobe, start_ok;
    logic [31:0] user_w, ctrl0, ctrl1, ivec, mfw;
    logic [4:0] code, last_code;
    int n_mismatch = 0, check_count = 0, n_strobe = 0, n_ser = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    cpp_link_if u_link ();
    cpp_host u_cpp_host (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(u_link));
    cpp_device #(.DEVICE_ID(OWN_ID), .FRAMES(2)) u_cpp_device (.sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in), .link(u_link), .serial_chain_out(ser), .chain_select_b_out(csel_b),
        .user_access_word_out(user_w), .control_word_0_out(ctrl0), .control_word_1_out(ctrl1),
        .cmd_strobe_out(strobe), .cmd_code_out(code), .start_ok_out(start_ok),
        .cipher_init_vector_out(ivec), .multi_frame_write_out(mfw));
    cpp_link_props u_cpp_link_props (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .wr_data(u_link.wr_data), .wr_valid(u_link.wr_valid), .wr_ready(u_link.wr_ready),
        .rd_data(u_link.rd_data), .rd_valid(u_link.rd_valid), .rd_ready(u_link.rd_ready));
    // Count command pulses and serial ones; a pulse lasts one cycle, a serial one too unless it is the last bit shifted, which the output holds
    always @(posedge sys_clk_in)
    begin
        if (strobe === 1'b1)
        begin
            n_strobe++;
            last_code = code;
        end
        if (ser === 1'b1) n_ser++;
    end
    // ------------------------------------------------------------------
    // Bus and stream helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] h1(input logic [1:0] op, input logic [4:0] a,
        input logic [10:0] n);
        return {3'h1, op, 9'h101, a, 2'h0, n}; // Upper address bits set, must be ignored
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do @(posedge sys_clk_in); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic send(input logic [31:0] w); apb(1'b1, 12'h000, w); endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] w);
        send(h1(2'h2, a, 11'h001)); send(w);
    endtask
    // Wait until the host has nothing pending, then let the device land it
    task automatic settle();
        q = 32'h1; while (q[0] !== 1'b0) apb(1'b0, 12'h004, 32'h0);
        repeat (4) @(posedge sys_clk_in);
    endtask
    task automatic get(output logic [31:0] w);
        q = 32'h0; while (q[1] !== 1'b1) apb(1'b0, 12'h004, 32'h0);
        apb(1'b0, 12'h008, 32'h0); w = q;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_parse();
        send({3'h2, 2'h0, 27'h1}); send(h1(2'h2, 5'h0D, 11'h001)); // Orphan data looks like header
        wreg(5'h0D, 32'h0000_C0DE); settle();
        check("user_after_orphan", 32'h0000_C0DE, user_w);
        // Reserved opcode carries one word that must be dropped, not stored
        send(h1(2'h3, 5'h0D, 11'h001)); send(32'h0000_0BAD);
        send(h1(2'h0, 5'h0D, 11'h000)); send(32'hE000_0000);
        settle();
        check("user_after_ignored", 32'h0000_C0DE, user_w);
        wreg(5'h0B, 32'h1111_2222); wreg(5'h0A, 32'h3333_4444); settle();
        check("init_vector", 32'h1111_2222, ivec);
        check("multi_frame", 32'h3333_4444, mfw);
        send(h1(2'h1, 5'h0D, 11'h001)); get(d);
        check("user_readback", 32'h0000_C0DE, d);
        $display("test parse done");
    endtask
    task automatic t_mask();
        wreg(5'h06, 32'h0000_FFFF); wreg(5'h05, 32'hFFFF_FFFF);
        send(h1(2'h2, 5'h18, 11'h001)); send(32'h0000_0001);
        send({3'h2, 2'h0, 27'h1}); send(32'hAAAA_5555); settle();
        check("control_0", 32'h0000_FFFF, ctrl0);
        check("control_1", 32'h0000_5555, ctrl1);
        wreg(5'h06, 32'hFFFF_FFFF);
        $display("test mask done");
    endtask
    task automatic t_cmd();
        int n0;
        n0 = n_strobe;
        wreg(5'h04, 32'h0000_0007); wreg(5'h01, 32'h0000_0000); settle();
        check("strobes", 32'(n0 + 2), 32'(n_strobe));
        check("code", 32'h0000_0007, {27'h0, last_code});
        $display("test command done");
    endtask
    task automatic t_frame();
        wreg(5'h0C, OWN_ID); wreg(5'h01, 32'h0000_0001);
        send(h1(2'h2, 5'h02, 11'd41));
        for (int i = 0; i < 41; i++) send(32'hF000_0000 + 32'(i * 7));
        wreg(5'h01, 32'h0000_0001); send(h1(2'h1, 5'h03, 11'd41));
        for (int i = 0; i < 41; i++)
        begin
            get(d);
            check("frame_word", 32'hF000_0000 + 32'(i * 7), d);
        end
        send(h1(2'h1, 5'h0C, 11'h001)); get(d);
        check("identifier", OWN_ID, d);
        send(h1(2'h1, 5'h07, 11'h001)); get(d);
        check("status_id_ok", 32'h0000_0002, d & 32'h0000_0002);
        $display("test frame done");
    endtask
    task automatic t_chain();
        n_ser = 0;
        wreg(5'h08, 32'h8000_0000); wreg(5'h0F, 32'h0000_0000); settle();
        check("serial_ones", 32'h1, 32'(n_ser));
        check("select_low", 32'h0, {31'h0, csel_b});
        wreg(5'h0F, 32'h0000_0001); settle();
        check("select_high", 32'h1, {31'h0, csel_b});
        $display("test chain done");
    endtask
    // Mid-run reset, so the running sum restarts at zero and is known
    task automatic t_crc();
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        check("start_reset", 32'h0, {31'h0, start_ok});
        wreg(5'h00, 32'h0000_0001); settle();
        check("start_bad_sum", 32'h0, {31'h0, start_ok});
        wreg(5'h00, 32'h0000_0000); settle();
        check("start_good_sum", 32'h1, {31'h0, start_ok});
        wreg(5'h0C, 32'h0000_0000); send(h1(2'h1, 5'h16, 11'h001)); get(d);
        check("boot_id_miss", 32'h1, d);
        wreg(5'h10, 32'h0000_4000); send(h1(2'h1, 5'h10, 11'h001)); get(d);
        check("warm_boot", 32'h0000_4000, d);
        apb(1'b0, 12'h00C, 32'h0);
        check("words_sent", 32'hA, q);
        $display("test check word done");
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_parse(); t_mask(); t_cmd(); t_frame(); t_chain(); t_crc();
        final_report();
    end
    // Watchdog well beyond the several hundred cycles the tests need
    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule // testbench
